// ### verilog/pcx_pkg.sv
// constants, signal codes and carrier types of the priority port crossbar
package pcx_pkg;

	localparam int NPIN = 23;
	localparam int NSIG = 26;
	localparam int NGEN = 20;

	typedef logic [4:0] pcx_sig_id_t;

	localparam pcx_sig_id_t SIG_NONE    = 5'h1f;
	localparam pcx_sig_id_t SIG_U0_TX   = 5'h00;
	localparam pcx_sig_id_t SIG_U0_RX   = 5'h01;
	localparam pcx_sig_id_t SIG_S1_SCK  = 5'h02;
	localparam pcx_sig_id_t SIG_S1_MISO = 5'h03;
	localparam pcx_sig_id_t SIG_S1_MOSI = 5'h04;
	localparam pcx_sig_id_t SIG_S1_SSEL = 5'h05;
	localparam pcx_sig_id_t SIG_S0_SCK  = 5'h06;
	localparam pcx_sig_id_t SIG_S0_MISO = 5'h07;
	localparam pcx_sig_id_t SIG_S0_MOSI = 5'h08;
	localparam pcx_sig_id_t SIG_S0_SSEL = 5'h09;
	localparam pcx_sig_id_t SIG_SMB_SDA = 5'h0a;
	localparam pcx_sig_id_t SIG_SMB_SCL = 5'h0b;
	localparam pcx_sig_id_t SIG_CP0     = 5'h0c;
	localparam pcx_sig_id_t SIG_CP0A    = 5'h0d;
	localparam pcx_sig_id_t SIG_CP1     = 5'h0e;
	localparam pcx_sig_id_t SIG_CP1A    = 5'h0f;
	localparam pcx_sig_id_t SIG_SYSCLK  = 5'h10;
	localparam pcx_sig_id_t SIG_CEX0    = 5'h11;
	localparam pcx_sig_id_t SIG_ECI     = 5'h17;
	localparam pcx_sig_id_t SIG_T0      = 5'h18;
	localparam pcx_sig_id_t SIG_T1      = 5'h19;
	localparam int          NUM_CEX     = 6;

	// fixed pin positions, index = port * 8 + bit
	localparam int PIN_U0_TX   = 4;
	localparam int PIN_U0_RX   = 5;
	localparam int PIN_S1_BASE = 16;

	// function_select_0 bits
	localparam int FS0_U0     = 0;
	localparam int FS0_S0     = 1;
	localparam int FS0_SMB    = 2;
	localparam int FS0_CP0    = 3;
	localparam int FS0_CP0A   = 4;
	localparam int FS0_CP1    = 5;
	localparam int FS0_CP1A   = 6;
	localparam int FS0_SYSCLK = 7;
	// function_select_1 bits
	localparam int FS1_CEX_LSB = 0;
	localparam int FS1_CEX_W   = 3;
	localparam int FS1_ECI     = 3;
	localparam int FS1_T0      = 4;
	localparam int FS1_T1      = 5;
	// function_select_2 bits
	localparam int FS2_S1      = 0;

	// placement order below the two fixed-pin peripherals
	localparam pcx_sig_id_t PRIO_ORDER [0:NGEN-1] = '{
		SIG_S0_SCK, SIG_S0_MISO, SIG_S0_MOSI, SIG_S0_SSEL, SIG_SMB_SDA, SIG_SMB_SCL,
		SIG_CP0, SIG_CP0A, SIG_CP1, SIG_CP1A, SIG_SYSCLK,
		5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16,
		SIG_ECI, SIG_T0, SIG_T1
	};

	localparam logic [NPIN-1:0] RST_PINS   = 23'h000000;
	localparam logic [NSIG-1:0] RST_SIGS   = 26'h0000000;
	localparam logic [NSIG-1:0] RST_SIG_DI = 26'h3ffffff;

	typedef struct packed {
		logic [7:0] fs2;
		logic [7:0] fs1;
		logic [7:0] fs0;
	} pcx_sel_t;

	typedef struct packed {
		logic [NPIN-1:0] skip;
		logic [NPIN-1:0] push_pull;
		logic [NPIN-1:0] drive_high;
		logic [NPIN-1:0] latch;
	} pcx_pin_cfg_t;

	typedef pcx_sig_id_t [NPIN-1:0] pcx_pin_map_t;

	function automatic logic pcx_four_wire(input logic [1:0] mode);
		return mode != 2'h0;
	endfunction

endpackage

// ### verilog/pcx_crossbar.sv
// priority crossbar: places selected peripheral signals on port pins and gates the drivers
`timescale 1ns/1ps
`default_nettype none
module pcx_crossbar (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_matrix_enable,
	input  wire pcx_pkg::pcx_sel_t      i_function_select,
	input  wire pcx_pkg::pcx_pin_cfg_t  i_pin_cfg,
	input  wire logic [1:0]             i_serial_if0_slave_select_mode,
	input  wire logic [1:0]             i_serial_if1_slave_select_mode,
	input  wire logic [pcx_pkg::NSIG-1:0] i_periph_do,
	input  wire logic [pcx_pkg::NSIG-1:0] i_periph_oe,
	input  wire logic [pcx_pkg::NPIN-1:0] i_pin_in,
	output var  logic [pcx_pkg::NPIN-1:0] o_pin_out,
	output var  logic [pcx_pkg::NPIN-1:0] o_pin_oe,
	output var  logic [pcx_pkg::NPIN-1:0] o_pin_drive_high,
	output var  logic [pcx_pkg::NSIG-1:0] o_periph_di,
	output var  logic [pcx_pkg::NSIG-1:0] o_sig_placed,
	output var  pcx_pkg::pcx_pin_map_t    o_pin_map
);
	import pcx_pkg::*;

	logic [NSIG-1:0]  sig_en;
	pcx_pin_map_t     map_nxt;
	logic [NPIN-1:0]  pin_out_nxt;
	logic [NPIN-1:0]  pin_oe_nxt;
	logic [NSIG-1:0]  di_nxt;
	logic [NSIG-1:0]  placed_nxt;

	// selected signals from the three function-select words
	always_comb begin
		logic [FS1_CEX_W-1:0] cex_cnt;
		cex_cnt = i_function_select.fs1[FS1_CEX_LSB +: FS1_CEX_W];
		sig_en = RST_SIGS;
		sig_en[SIG_U0_TX]   = i_function_select.fs0[FS0_U0];
		sig_en[SIG_U0_RX]   = i_function_select.fs0[FS0_U0];
		sig_en[SIG_S1_SCK]  = i_function_select.fs2[FS2_S1];
		sig_en[SIG_S1_MISO] = i_function_select.fs2[FS2_S1];
		sig_en[SIG_S1_MOSI] = i_function_select.fs2[FS2_S1];
		sig_en[SIG_S1_SSEL] = i_function_select.fs2[FS2_S1] & pcx_four_wire(i_serial_if1_slave_select_mode);
		sig_en[SIG_S0_SCK]  = i_function_select.fs0[FS0_S0];
		sig_en[SIG_S0_MISO] = i_function_select.fs0[FS0_S0];
		sig_en[SIG_S0_MOSI] = i_function_select.fs0[FS0_S0];
		sig_en[SIG_S0_SSEL] = i_function_select.fs0[FS0_S0] & pcx_four_wire(i_serial_if0_slave_select_mode);
		sig_en[SIG_SMB_SDA] = i_function_select.fs0[FS0_SMB];
		sig_en[SIG_SMB_SCL] = i_function_select.fs0[FS0_SMB];
		sig_en[SIG_CP0]     = i_function_select.fs0[FS0_CP0];
		sig_en[SIG_CP0A]    = i_function_select.fs0[FS0_CP0A];
		sig_en[SIG_CP1]     = i_function_select.fs0[FS0_CP1];
		sig_en[SIG_CP1A]    = i_function_select.fs0[FS0_CP1A];
		sig_en[SIG_SYSCLK]  = i_function_select.fs0[FS0_SYSCLK];
		for (int k = 0; k < NUM_CEX; k++) begin
			sig_en[int'(SIG_CEX0) + k] = FS1_CEX_W'(k) < cex_cnt;
		end
		sig_en[SIG_ECI]     = i_function_select.fs1[FS1_ECI];
		sig_en[SIG_T0]      = i_function_select.fs1[FS1_T0];
		sig_en[SIG_T1]      = i_function_select.fs1[FS1_T1];
	end

	// pin assignment
	always_comb begin
		logic [NPIN-1:0] taken;
		logic            found;
		pcx_sig_id_t     id;
		taken = RST_PINS;
		found = 1'b0;
		id = SIG_NONE;
		for (int p = 0; p < NPIN; p++) begin
			map_nxt[p] = SIG_NONE;
		end
		// fixed placements, dropped if the pin is skipped
		if (sig_en[SIG_U0_TX] && !i_pin_cfg.skip[PIN_U0_TX]) begin
			map_nxt[PIN_U0_TX] = SIG_U0_TX;
			taken[PIN_U0_TX] = 1'b1;
		end
		if (sig_en[SIG_U0_RX] && !i_pin_cfg.skip[PIN_U0_RX]) begin
			map_nxt[PIN_U0_RX] = SIG_U0_RX;
			taken[PIN_U0_RX] = 1'b1;
		end
		for (int k = 0; k < 4; k++) begin
			if (sig_en[int'(SIG_S1_SCK) + k] && !i_pin_cfg.skip[PIN_S1_BASE + k]) begin
				map_nxt[PIN_S1_BASE + k] = pcx_sig_id_t'(int'(SIG_S1_SCK) + k);
				taken[PIN_S1_BASE + k] = 1'b1;
			end
		end
		// remaining signals take the lowest free candidate pin in priority order
		for (int r = 0; r < NGEN; r++) begin
			id = PRIO_ORDER[r];
			found = 1'b0;
			if (sig_en[id]) begin
				for (int p = 0; p < NPIN; p++) begin
					if (!found && !taken[p] && !i_pin_cfg.skip[p]) begin
						map_nxt[p] = id;
						taken[p] = 1'b1;
						found = 1'b1;
					end
				end
			end
		end
	end

	// driver gating and input return
	always_comb begin
		pcx_sig_id_t id;
		logic        od;
		id = SIG_NONE;
		od = 1'b0;
		pin_out_nxt = RST_PINS;
		pin_oe_nxt = RST_PINS;
		di_nxt = RST_SIG_DI;
		placed_nxt = RST_SIGS;
		for (int p = 0; p < NPIN; p++) begin
			id = map_nxt[p];
			if (id != SIG_NONE) begin
				di_nxt[id] = i_pin_in[p];
				placed_nxt[id] = 1'b1;
				od = !i_pin_cfg.push_pull[p] || id == SIG_SMB_SDA || id == SIG_SMB_SCL;
				if (od) begin
					pin_out_nxt[p] = 1'b0;
					pin_oe_nxt[p] = i_periph_oe[id] & ~i_periph_do[id];
				end else begin
					pin_out_nxt[p] = i_periph_do[id];
					pin_oe_nxt[p] = i_periph_oe[id];
				end
			end else if (i_pin_cfg.push_pull[p]) begin
				pin_out_nxt[p] = i_pin_cfg.latch[p];
				pin_oe_nxt[p] = 1'b1;
			end else begin
				pin_out_nxt[p] = 1'b0;
				pin_oe_nxt[p] = ~i_pin_cfg.latch[p];
			end
			if (!i_matrix_enable) begin
				pin_oe_nxt[p] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin_out <= RST_PINS;
			o_pin_oe <= RST_PINS;
		end else begin
			o_pin_out <= pin_out_nxt;
			o_pin_oe <= pin_oe_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin_drive_high <= RST_PINS;
		end else begin
			o_pin_drive_high <= i_pin_cfg.drive_high;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_periph_di <= RST_SIG_DI;
			o_sig_placed <= RST_SIGS;
			o_pin_map <= {NPIN{SIG_NONE}};
		end else begin
			o_periph_di <= di_nxt;
			o_sig_placed <= placed_nxt;
			o_pin_map <= map_nxt;
		end
	end

endmodule
`default_nettype wire

// ### sim/pcx_pin_model.sv
// outside pads of the port pins, each with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pcx_pin_model (
	input  wire logic [pcx_pkg::NPIN-1:0] i_pin_out,
	input  wire logic [pcx_pkg::NPIN-1:0] i_pin_oe,
	output var  logic [pcx_pkg::NPIN-1:0] o_pin_in
);
	import pcx_pkg::*;
	// an undriven pin floats high through its pull-up
	assign o_pin_in = (i_pin_out & i_pin_oe) | ~i_pin_oe;
endmodule
`default_nettype wire

// ### sim/pcx_crossbar_props.sv
// assertions on the crossbar ports
`timescale 1ns/1ps
`default_nettype none
module pcx_crossbar_props (
	input wire logic                      i_ref_clk,
	input wire logic                      i_rst,
	input wire logic                      i_matrix_enable,
	input wire pcx_pkg::pcx_sel_t         i_function_select,
	input wire pcx_pkg::pcx_pin_cfg_t     i_pin_cfg,
	input wire logic [1:0]                i_serial_if0_slave_select_mode,
	input wire logic [1:0]                i_serial_if1_slave_select_mode,
	input wire logic [pcx_pkg::NPIN-1:0]  o_pin_out,
	input wire logic [pcx_pkg::NPIN-1:0]  o_pin_oe,
	input wire logic [pcx_pkg::NPIN-1:0]  o_pin_drive_high,
	input wire logic [pcx_pkg::NSIG-1:0]  o_sig_placed,
	input wire pcx_pkg::pcx_pin_map_t     o_pin_map
);
	import pcx_pkg::*;
	logic            live_r;
	logic [NPIN-1:0] took_w;
	logic [NPIN-1:0] smb_w;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// outputs lag inputs by one edge, so the first edge out of reset is not judged
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) live_r <= 1'b0;
		else live_r <= 1'b1;
	end
	always_comb begin
		for (int p = 0; p < NPIN; p++) begin
			took_w[p] = o_pin_map[p] != SIG_NONE;
			smb_w[p] = o_pin_map[p] == SIG_SMB_SDA || o_pin_map[p] == SIG_SMB_SCL;
		end
	end
	sequence s_sif1_on;
		live_r ##0 $past(i_function_select.fs2[FS2_S1]);
	endsequence
	chk_drivers_off: assert property (live_r && !$past(i_matrix_enable) |-> o_pin_oe == '0)
		else $error("driver on while disabled");
	chk_skip_kept: assert property (live_r |-> (took_w & $past(i_pin_cfg.skip)) == '0)
		else $error("skipped pin claimed");
	chk_uart_pins: assert property (live_r && $past(i_function_select.fs0[FS0_U0])
		&& $past(!i_pin_cfg.skip[PIN_U0_TX]) |-> o_pin_map[PIN_U0_TX] == SIG_U0_TX)
		else $error("uart pin wrong");
	chk_sif1_pins: assert property (s_sif1_on ##0 $past(!i_pin_cfg.skip[PIN_S1_BASE])
		|-> o_pin_map[PIN_S1_BASE] == SIG_S1_SCK)
		else $error("second serial clock pin wrong");
	chk_sif1_select: assert property (s_sif1_on ##0 $past(!i_pin_cfg.skip[PIN_S1_BASE+3]) |->
		(o_pin_map[PIN_S1_BASE+3] == SIG_S1_SSEL) == $past(i_serial_if1_slave_select_mode != 2'h0))
		else $error("second serial select pin wrong");
	chk_sif0_three: assert property (live_r && $past(i_serial_if0_slave_select_mode == 2'h0)
		|-> !o_sig_placed[SIG_S0_SSEL])
		else $error("first serial select placed in three-wire");
	chk_smb_open: assert property (live_r |-> (o_pin_out & smb_w) == '0)
		else $error("bus pin driven high");
	chk_drive_copy: assert property (live_r |-> o_pin_drive_high == $past(i_pin_cfg.drive_high))
		else $error("drive strength wrong");
	chk_fn_select: assert property (live_r && $past(i_function_select == '0) |-> o_sig_placed == '0)
		else $error("signal placed unselected");
endmodule
bind pcx_crossbar pcx_crossbar_props pcx_crossbar_props_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_matrix_enable(i_matrix_enable), .i_function_select(i_function_select), .i_pin_cfg(i_pin_cfg),
	.i_serial_if0_slave_select_mode(i_serial_if0_slave_select_mode),
	.i_serial_if1_slave_select_mode(i_serial_if1_slave_select_mode), .o_pin_out(o_pin_out),
	.o_pin_oe(o_pin_oe), .o_pin_drive_high(o_pin_drive_high), .o_sig_placed(o_sig_placed), .o_pin_map(o_pin_map));
`default_nettype wire

// ### sim/pcx_crossbar_tb.sv
// self-checking bench for the priority crossbar
`timescale 1ns/1ps
`default_nettype none
module pcx_crossbar_tb;
	import pcx_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         en = 1'b0;
	logic [1:0]   m0 = 2'h0;
	logic [1:0]   m1 = 2'h0;
	pcx_sel_t     sel = '0;
	pcx_pin_cfg_t cfg = '1;
	logic [NSIG-1:0] pdo = '0, poe = '0, di, placed;
	logic [NPIN-1:0] pin, pout, oe, dh;
	pcx_pin_map_t map;
	int failures = 0;
	int checked = 0;
	always #4 clk = ~clk;
	pcx_crossbar pcx_crossbar_i (.i_ref_clk(clk), .i_rst(rst), .i_matrix_enable(en), .i_function_select(sel),
		.i_pin_cfg(cfg), .i_serial_if0_slave_select_mode(m0), .i_serial_if1_slave_select_mode(m1),
		.i_periph_do(pdo), .i_periph_oe(poe), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(oe),
		.o_pin_drive_high(dh), .o_periph_di(di), .o_sig_placed(placed), .o_pin_map(map));
	pcx_pin_model pcx_pin_model_i (.i_pin_out(pout), .i_pin_oe(oe), .o_pin_in(pin));
	task automatic cmp(input logic [127:0] g, input logic [127:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// outputs held by reset
	task automatic reset_vals();
		cmp(pout, '0);
		cmp(oe, '0);
		cmp(dh, '0);
		cmp(placed, '0);
		cmp(di, {NSIG{1'b1}});
		cmp(map, {NPIN{SIG_NONE}});
	endtask
	task automatic check(input string n);
		pcx_pin_map_t m;
		logic [NSIG-1:0] w, ep, ed;
		logic [NPIN-1:0] eo, ev, lv;
		int p, s;
		@(posedge clk);
		#1;
		m = {NPIN{SIG_NONE}};
		w = {sel.fs1[5:3], 6'h00, sel.fs0[7:3], {2{sel.fs0[FS0_SMB]}}, sel.fs0[FS0_S0] && m0 != 2'h0,
			{3{sel.fs0[FS0_S0]}}, sel.fs2[FS2_S1] && m1 != 2'h0, {3{sel.fs2[FS2_S1]}}, {2{sel.fs0[FS0_U0]}}};
		for (int k = 0; k < NUM_CEX; k++) w[SIG_CEX0 + k] = k < sel.fs1[2:0];
		for (s = 0; s < 6; s++) begin
			p = s < 2 ? PIN_U0_TX + s : PIN_S1_BASE + s - 2;
			if (w[s] && !cfg.skip[p]) m[p] = 5'(s);
		end
		for (int g = 0; g < NGEN; g++) begin
			p = 0;
			while (p < NPIN && (cfg.skip[p] || m[p] !== SIG_NONE)) p++;
			if (w[PRIO_ORDER[g]] && p < NPIN) m[p] = PRIO_ORDER[g];
		end
		ep = '0;
		for (p = 0; p < NPIN; p++) begin
			s = m[p];
			if (m[p] === SIG_NONE) {eo[p], ev[p]} = cfg.push_pull[p] ? {1'b1, cfg.latch[p]} : {!cfg.latch[p], 1'b0};
			else if (cfg.push_pull[p] && s != SIG_SMB_SDA && s != SIG_SMB_SCL) {eo[p], ev[p]} = {poe[s], pdo[s]};
			else {eo[p], ev[p]} = {poe[s] & !pdo[s], 1'b0};
			if (m[p] !== SIG_NONE) ep[s] = 1'b1;
		end
		cmp(map, m);
		cmp(placed, ep);
		cmp(oe, en ? eo : '0);
		cmp(pout, ev);
		cmp(dh, cfg.drive_high);
		// pad levels come back to the placed signals one edge later, undriven pads read high
		ed = '1;
		for (p = 0; p < NPIN; p++) begin
			lv[p] = (en && eo[p]) ? ev[p] : 1'b1;
			if (m[p] !== SIG_NONE) ed[m[p]] = lv[p];
		end
		@(posedge clk);
		#1;
		cmp(di, ed);
		$display("test %s done", n);
	endtask
	task automatic set(input string n, input logic [23:0] s, input logic [NPIN-1:0] k, input logic [3:0] md,
		input logic e);
		@(posedge clk);
		sel <= s;
		cfg <= '{k, ~k, '0, '1};
		{m0, m1} <= md;
		en <= e;
		pdo <= NSIG'($urandom);
		poe <= NSIG'($urandom);
		check(n);
	endtask
	task automatic conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#40000;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(77679));
		repeat (9) @(posedge clk);
		#1;
		reset_vals();
		@(posedge clk);
		rst <= 1'b0;
		set("uart", 24'h000001, 23'h000000, 4'h0, 1'b1);
		set("sif1_four", 24'h010000, 23'h000000, 4'h1, 1'b1);
		set("sif0_three", 24'h000002, 23'h000000, 4'h0, 1'b1);
		set("sif0_four", 24'h000006, 23'h000000, 4'h8, 1'b1);
		set("crowded", 24'h013fff, 23'h00000c, 4'h6, 1'b1);
		set("fixed_skip", 24'h010001, 23'h0f0030, 4'h3, 1'b1);
		// skipped pins are left open-drain with the latch high
		set("analog", 24'h0000fe, 23'h7fff0f, 4'h0, 1'b1);
		set("disabled", 24'h0000ff, 23'h000000, 4'h0, 1'b0);
		// reset again in mid-run
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		reset_vals();
		@(posedge clk);
		rst <= 1'b0;
		$display("test reset done");
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			sel <= 24'($urandom);
			cfg <= 92'({$urandom, $urandom, $urandom});
			{m0, m1} <= 4'($urandom);
			en <= ($urandom % 8) != 0;
			pdo <= NSIG'($urandom);
			poe <= NSIG'($urandom);
			check("random");
		end
		conclude();
	end
endmodule
`default_nettype wire
